// File: rtl/atd_pkg.sv
package atd_pkg;
   // fifo geometry: 35 entries of 36 bits, 6-bit fill counter
   localparam int FIFO_DEPTH = 35;
   localparam int FIFO_WIDTH = 36;
   localparam int CNT_W = 6;
   localparam logic [5:0] FIFO_LAST = 6'h22;
   localparam logic [5:0] FIFO_FULL_CNT = 6'h23;
   // instruction word fields
   localparam int OP_MSB = 31;
   localparam int OP_LSB = 28;
   localparam int LEN_MSB = 11;
   localparam int LEN_LSB = 0;
   // instruction opcodes; anything else is refused
   localparam logic [3:0] OP_WRITE = 4'h1;
   localparam logic [3:0] OP_JUMP = 4'h7;
   localparam logic [3:0] OP_STOP = 4'h9;
   // address step of one dword and reset values
   localparam logic [31:0] DW_STEP = 32'h0000_0004;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   localparam logic [11:0] LEN_ONE = 12'h001;
   localparam logic [3:0] BE_ALL = 4'hF;
   // bus-master request as it leaves the block
   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [31:0] data;
   } atd_bm_req_t;
   // one fifo entry: byte enables plus data, 36 bits
   typedef struct packed {
      logic [3:0] be;
      logic [31:0] data;
   } atd_ent_t;
   // instruction sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FETCH_OP,
      ST_FETCH_ADDR,
      ST_WRITE
   } atd_state_t;
endpackage : atd_pkg

// File: rtl/atd_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module atd_fifo
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_push,
   input wire atd_pkg::atd_ent_t i_wdata,
   input wire logic i_pop,
   output atd_pkg::atd_ent_t o_rdata,
   output logic o_full,
   output logic o_empty,
   output logic [5:0] o_count
);
   // storage array, show-ahead read of the head entry
   atd_pkg::atd_ent_t mem [atd_pkg::FIFO_DEPTH];
   logic [5:0] wr_r; // write pointer
   logic [5:0] rd_r; // read pointer
   logic [5:0] cnt_r; // dword fill counter
   logic do_push;
   logic do_pop;
   // every check below runs on the bus clock and sleeps in reset
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   // a push into a full fifo is dropped here; the caller flags it
   assign do_push = i_push && !o_full;
   assign do_pop = i_pop && !o_empty;
   assign o_full = (cnt_r == atd_pkg::FIFO_FULL_CNT);
   assign o_empty = (cnt_r == 6'h00);
   assign o_count = cnt_r;
   assign o_rdata = mem[rd_r];

   // pointer advance wraps at the last of the 35 entries
   function automatic logic [5:0] atd_wrap(input logic [5:0] p);
      atd_wrap = (p == atd_pkg::FIFO_LAST) ? 6'h00 : p + 6'h01;
   endfunction : atd_wrap

   // data store has no reset, contents are qualified by the counter
   always_ff @(posedge i_clk)
   begin
      if (do_push)
      begin
         mem[wr_r] <= i_wdata;
      end
   end

   // pointers and fill counter
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wr_r <= 6'h00;
         rd_r <= 6'h00;
         cnt_r <= 6'h00;
      end
      else
      begin
         if (do_push)
         begin
            wr_r <= atd_wrap(wr_r);
         end
         if (do_pop)
         begin
            rd_r <= atd_wrap(rd_r);
         end
         cnt_r <= cnt_r + {5'h00, do_push} - {5'h00, do_pop}; // [R6]
      end
   end

   fifo_cnt_max_a: assert property ( // [R6]
      cnt_r <= atd_pkg::FIFO_FULL_CNT)
      else $error("fill counter above fifo depth");
   fifo_full_hold_a: assert property ( // [R6]
      (o_full && i_push && !i_pop) |=> o_full && $stable(wr_r))
      else $error("push into full fifo was stored");
endmodule : atd_fifo
`default_nettype wire

// File: rtl/atd_dma_top.sv
// Operation
// [R1] packs 8 or 16-bit samples into whole dwords
// [R2] fetches and runs its own instruction program
// [R3] runs independently of any video channel
// [R4] captures continuously, never pausing for sync
// [R5] accepts packed write instructions only, refuses others; the code also accepts jump and stop opcodes
// [R6] single 35x36 fifo with 6-bit counter
// [R7] retried transfer is reissued by this initiator
// [R8] control stays in the bus clock domain
// [R9] target side never disconnects or retries
// [R10] status, interrupt source and parity like video
// [R11] transport streams use this channel, not video
// [R12] serial transport shares audio serial pins, 40 Mbps
// [R13] parallel transport via gpio port, 20 Mbps
// [R14] data leaves as 32-bit dword writes
// [R15] overflow drops data, flags overrun, then resumes
`timescale 1ns/100ps
`default_nettype none
module atd_dma_top
(
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_enable,
   input wire logic [31:0] i_prog_base,
   input wire logic i_src_par,
   input wire logic i_wide,
   input wire logic i_ser_clk,
   input wire logic i_ser_dat,
   input wire logic i_par_stb,
   input wire logic [15:0] i_gpio,
   input wire logic i_bm_ack,
   input wire logic i_bm_retry,
   input wire logic [31:0] i_bm_rdata,
   input wire logic i_ovr_clr,
   output atd_pkg::atd_bm_req_t o_bm,
   output logic o_bm_par,
   output logic o_overrun,
   output logic o_instr_err,
   output logic o_busy,
   output logic [5:0] o_fill
);
   // pin synchronisers; stage 1 feeds only stage 2
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [1:0] prev_r; // previous stage-2 clock and strobe
   logic [15:0] g1_r;
   logic [15:0] g2_r;
   // packer state
   logic [15:0] sh_r; // serial shift register
   logic [3:0] bit_r; // serial bit count within a unit
   logic [31:0] acc_r; // dword being assembled
   logic [1:0] bpos_r; // next free byte lane
   logic push_r; // one-cycle fifo push
   atd_pkg::atd_ent_t pdat_r;
   // sequencer state
   atd_pkg::atd_state_t st_r;
   logic [31:0] pc_r;
   logic [31:0] waddr_r;
   logic [11:0] len_r;
   logic jump_r;
   logic en_q_r; // enable as seen one clock ago
   atd_pkg::atd_bm_req_t bm_r;
   logic par_r;
   logic ovr_r;
   logic err_r;
   logic busy_r;
   logic [5:0] fill_r;
   // fifo ports
   atd_pkg::atd_ent_t f_rdata;
   logic f_full;
   logic f_empty;
   logic f_pop;
   logic [5:0] f_count;
   // combinational helpers
   logic ser_edge;
   logic par_edge;
   logic unit_rdy;
   logic [15:0] unit;
   logic [3:0] op;
   logic ovr_set;
   // all checks of this module run on the bus clock, off in reset
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   // merges a unit at a byte lane into the dword under assembly
   function automatic logic [31:0] atd_merge(input logic [31:0] acc,
      input logic [15:0] u, input logic [1:0] pos, input logic wide);
      logic [31:0] m;
      m = wide ? {16'h0000, u} : {24'h000000, u[7:0]};
      atd_merge = acc | (m << {pos, 3'b000});
   endfunction : atd_merge

   // two-flop sampling of the serial pins and gpio strobe; the gpio
   // bus goes through the same two stages so it lines up with its
   // strobe, which relies on the source holding data around it
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         s1_r <= 3'h0;
         s2_r <= 3'h0;
         prev_r <= 2'h0;
         g1_r <= 16'h0000;
         g2_r <= 16'h0000;
      end
      else
      begin
         s1_r <= {i_par_stb, i_ser_dat, i_ser_clk}; // [R12] [R13]
         s2_r <= s1_r;
         prev_r <= {s2_r[2], s2_r[0]};
         g1_r <= i_gpio;
         g2_r <= g1_r;
      end
   end

   // 40 Mbps is 25 ns per bit, about three 8 ns clocks, so each level
   // of the bit clock is still sampled at least once
   assign ser_edge = s2_r[0] && !prev_r[0] && !i_src_par; // [R12]
   assign par_edge = s2_r[2] && !prev_r[1] && i_src_par; // [R13]
   assign unit_rdy = par_edge
      || (ser_edge && (bit_r == (i_wide ? 4'hF : 4'h7)));
   assign unit = i_src_par ? g2_r : {sh_r[14:0], s2_r[1]};
   // a whole dword that finds the fifo full is lost
   assign ovr_set = push_r && f_full; // [R15]

   // serial shift, msb first, one unit per 8 or 16 bits
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         sh_r <= 16'h0000;
         bit_r <= 4'h0;
      end
      else if (!i_enable)
      begin
         bit_r <= 4'h0;
      end
      else if (ser_edge)
      begin
         sh_r <= {sh_r[14:0], s2_r[1]};
         bit_r <= unit_rdy ? 4'h0 : bit_r + 4'h1;
      end
   end

   // dword packer runs on every unit with no sync gaps, audio or
   // transport alike; only full dwords are ever pushed
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         acc_r <= 32'h0000_0000;
         bpos_r <= 2'h0;
         push_r <= 1'b0;
         pdat_r <= '0;
      end
      else
      begin
         push_r <= 1'b0;
         if (!i_enable)
         begin
            acc_r <= 32'h0000_0000;
            bpos_r <= 2'h0;
         end
         else if (unit_rdy) // [R4] [R11]
         begin
            if (bpos_r == (i_wide ? 2'h2 : 2'h3)) // [R1]
            begin
               pdat_r <= '{be: atd_pkg::BE_ALL,
                  data: atd_merge(acc_r, unit, bpos_r, i_wide)};
               push_r <= 1'b1;
               acc_r <= 32'h0000_0000;
               bpos_r <= 2'h0;
            end
            else
            begin
               acc_r <= atd_merge(acc_r, unit, bpos_r, i_wide);
               bpos_r <= bpos_r + (i_wide ? 2'h2 : 2'h1);
            end
         end
      end
   end

   // overrun flag: set wins over a clear in the same cycle, and
   // capture resumes on its own as soon as an entry frees
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         ovr_r <= 1'b0;
      end
      else
      begin
         ovr_r <= ovr_set || (ovr_r && !i_ovr_clr); // [R15] [R10]
      end
   end

   // the only buffer of the channel
   atd_fifo u_fifo
   (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_push(push_r),
      .i_wdata(pdat_r),
      .i_pop(f_pop),
      .o_rdata(f_rdata),
      .o_full(f_full),
      .o_empty(f_empty),
      .o_count(f_count)
   );

   assign op = i_bm_rdata[atd_pkg::OP_MSB:atd_pkg::OP_LSB];
   // head entry leaves only once the write is accepted
   assign f_pop = (st_r == atd_pkg::ST_WRITE) && bm_r.valid && i_bm_ack;

   // instruction sequencer; nothing here waits on another channel
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_r <= atd_pkg::ST_IDLE;
         pc_r <= atd_pkg::ADDR_RST;
         waddr_r <= atd_pkg::ADDR_RST;
         len_r <= 12'h000;
         jump_r <= 1'b0;
         err_r <= 1'b0;
      end
      else
      begin
         case (st_r)
            atd_pkg::ST_IDLE:
            begin
               // only a fresh rise of the enable starts a program, so a
               // stop with the enable still high does not loop back
               if (i_enable && !en_q_r) // [R2] [R3]
               begin
                  pc_r <= i_prog_base;
                  err_r <= 1'b0;
                  st_r <= atd_pkg::ST_FETCH_OP;
               end
            end
            atd_pkg::ST_FETCH_OP:
            begin
               if (bm_r.valid && i_bm_ack)
               begin
                  pc_r <= pc_r + atd_pkg::DW_STEP;
                  len_r <= i_bm_rdata[atd_pkg::LEN_MSB:atd_pkg::LEN_LSB];
                  jump_r <= (op == atd_pkg::OP_JUMP);
                  if (op == atd_pkg::OP_WRITE || op == atd_pkg::OP_JUMP)
                  begin
                     st_r <= atd_pkg::ST_FETCH_ADDR;
                  end
                  else if (op == atd_pkg::OP_STOP)
                  begin
                     st_r <= atd_pkg::ST_IDLE;
                  end
                  else
                  begin
                     err_r <= 1'b1; // [R5]
                     st_r <= atd_pkg::ST_IDLE;
                  end
               end
            end
            atd_pkg::ST_FETCH_ADDR:
            begin
               if (bm_r.valid && i_bm_ack)
               begin
                  if (jump_r)
                  begin
                     pc_r <= i_bm_rdata;
                     st_r <= atd_pkg::ST_FETCH_OP;
                  end
                  else
                  begin
                     pc_r <= pc_r + atd_pkg::DW_STEP;
                     waddr_r <= i_bm_rdata;
                     st_r <= (len_r == 12'h000) ? atd_pkg::ST_FETCH_OP
                        : atd_pkg::ST_WRITE;
                  end
               end
            end
            atd_pkg::ST_WRITE:
            begin
               if (bm_r.valid && i_bm_ack) // [R14]
               begin
                  waddr_r <= waddr_r + atd_pkg::DW_STEP;
                  len_r <= len_r - atd_pkg::LEN_ONE;
                  if (len_r == atd_pkg::LEN_ONE)
                  begin
                     st_r <= atd_pkg::ST_FETCH_OP;
                  end
               end
               else if (!i_enable && !bm_r.valid)
               begin
                  st_r <= atd_pkg::ST_IDLE;
               end
            end
            default:
            begin
               st_r <= atd_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // bus request: held through retries, dropped on the acknowledge;
   // fetches are reads, data moves as single dword writes
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         bm_r <= '0;
         par_r <= 1'b0;
      end
      else if (bm_r.valid)
      begin
         if (i_bm_ack)
         begin
            bm_r.valid <= 1'b0;
         end
         // a retry leaves the request standing for reissue [R7]
      end
      else if (st_r == atd_pkg::ST_FETCH_OP
         || st_r == atd_pkg::ST_FETCH_ADDR)
      begin
         bm_r <= '{valid: 1'b1, we: 1'b0, addr: pc_r, data: 32'h0000_0000};
         par_r <= 1'b0;
      end
      // no new write once disabled: the sequencer leaves for idle in
      // that same cycle and would strand the request
      else if (st_r == atd_pkg::ST_WRITE && !f_empty && i_enable)
      begin
         bm_r <= '{valid: 1'b1, we: 1'b1, addr: waddr_r,
            data: f_rdata.data}; // [R14]
         par_r <= ^f_rdata.data; // [R10]
      end
   end

   // status outputs, all registered; plain level ports need no
   // handshake, so a status read is never refused [R8] [R9]
   always_ff @(posedge i_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         busy_r <= 1'b0;
         fill_r <= 6'h00;
         en_q_r <= 1'b0;
      end
      else
      begin
         busy_r <= (st_r != atd_pkg::ST_IDLE);
         fill_r <= f_count; // [R6]
         en_q_r <= i_enable; // [R2]
      end
   end

   assign o_bm = bm_r;
   assign o_bm_par = par_r;
   assign o_overrun = ovr_r;
   assign o_instr_err = err_r;
   assign o_busy = busy_r;
   assign o_fill = fill_r;

   overrun_set_a: assert property ( // [R15]
      (push_r && f_full) |=> o_overrun)
      else $error("dropped dword did not flag overrun");
   overrun_clr_a: assert property ( // [R15]
      (i_ovr_clr && !(push_r && f_full)) |=> !o_overrun)
      else $error("overrun clear ignored");
   retry_hold_a: assert property ( // [R7]
      (bm_r.valid && i_bm_retry && !i_bm_ack)
      |=> bm_r.valid && $stable(bm_r.addr) && $stable(bm_r.we))
      else $error("retried request not reissued");
   bus_parity_a: assert property ( // [R10]
      (bm_r.valid && bm_r.we) |-> (o_bm_par == ^bm_r.data))
      else $error("parity does not match write data");
   fetch_read_a: assert property ( // [R2]
      (bm_r.valid && st_r == atd_pkg::ST_FETCH_OP) |-> !bm_r.we)
      else $error("instruction fetch issued as write");
   bad_op_a: assert property ( // [R5]
      (st_r == atd_pkg::ST_FETCH_OP && bm_r.valid && i_bm_ack
       && op != atd_pkg::OP_WRITE && op != atd_pkg::OP_JUMP
       && op != atd_pkg::OP_STOP)
      |=> o_instr_err && st_r == atd_pkg::ST_IDLE)
      else $error("unsupported instruction not refused");
   whole_dword_a: assert property ( // [R1]
      push_r |-> (pdat_r.be == atd_pkg::BE_ALL) && (bpos_r == 2'h0))
      else $error("partial dword pushed");
   write_end_a: assert property ( // [R14]
      (st_r == atd_pkg::ST_WRITE && bm_r.valid && i_bm_ack
       && len_r == atd_pkg::LEN_ONE)
      |=> st_r == atd_pkg::ST_FETCH_OP ##1 bm_r.valid)
      else $error("write run did not return to fetch");
endmodule : atd_dma_top
`default_nettype wire

// File: tb/atd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module atd_host_model
(
   input wire logic i_clk,
   input wire atd_pkg::atd_bm_req_t i_req,
   input wire logic i_par,
   input wire logic i_stall,
   input wire logic i_retry_once,
   output logic o_ack,
   output logic o_retry,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:255]; // dword memory, low 1 kbyte
   int wr_cnt = 0; // writes completed so far
   int par_bad = 0; // writes seen with wrong parity
   logic retry_done = 1'b0; // one retry per arming
   initial
   begin
      o_ack = 1'b0;
      o_retry = 1'b0;
      o_rdata = 32'h0000_0000;
   end
   // one request at a time, answered one cycle after it is seen
   always @(posedge i_clk)
   begin
      o_ack <= 1'b0;
      o_retry <= 1'b0;
      o_rdata <= ~o_rdata; // released data never keeps the old word
      if (!i_retry_once)
         retry_done <= 1'b0;
      if (i_req.valid && !o_ack && !o_retry && !i_stall)
      begin
         if (i_retry_once && !retry_done)
         begin
            // target busy once: the request has to stay up
            o_retry <= 1'b1;
            retry_done <= 1'b1;
         end
         else if (i_req.we)
         begin
            // dword write lands whole
            mem[i_req.addr[9:2]] <= i_req.data;
            wr_cnt <= wr_cnt + 1;
            if (i_par !== ^i_req.data)
               par_bad <= par_bad + 1;
            o_ack <= 1'b1;
         end
         else
         begin
            o_rdata <= mem[i_req.addr[9:2]]; // instruction fetch
            o_ack <= 1'b1;
         end
      end
   end
endmodule : atd_host_model
`default_nettype wire

// File: tb/audio_transport_dma_test.sv
`timescale 1ns/100ps
`default_nettype none
module audio_transport_dma_test;
   logic clk = 1'b0; // 125 MHz
   logic rstn = 1'b0; // active-low reset
   logic enable = 1'b0;
   logic [31:0] prog_base = 32'h0000_0000;
   logic src_par = 1'b0;
   logic wide = 1'b0;
   logic ser_clk = 1'b0; // stands low between units
   logic ser_dat = 1'b0;
   logic par_stb = 1'b0;
   logic [15:0] gpio = 16'h0000;
   logic ovr_clr = 1'b0;
   logic stall = 1'b0; // host holds off every answer
   logic retry_once = 1'b0; // host retries the next request
   logic ack, retry, bm_par, overrun, instr_err, busy;
   logic [31:0] rdata;
   logic [5:0] fill;
   atd_pkg::atd_bm_req_t bm;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int w; // write count snapshot
   atd_dma_top dut (.i_clk(clk), .i_rstn(rstn), .i_enable(enable),
      .i_prog_base(prog_base), .i_src_par(src_par), .i_wide(wide),
      .i_ser_clk(ser_clk), .i_ser_dat(ser_dat), .i_par_stb(par_stb),
      .i_gpio(gpio), .i_bm_ack(ack), .i_bm_retry(retry),
      .i_bm_rdata(rdata), .i_ovr_clr(ovr_clr), .o_bm(bm),
      .o_bm_par(bm_par), .o_overrun(overrun), .o_instr_err(instr_err),
      .o_busy(busy), .o_fill(fill));
   atd_host_model part (.i_clk(clk), .i_req(bm), .i_par(bm_par),
      .i_stall(stall), .i_retry_once(retry_once), .o_ack(ack),
      .o_retry(retry), .o_rdata(rdata));
   initial
   begin
      forever #4 clk = ~clk;
   end
   task automatic wrap_up();
      if (miscompares == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   // a hang is cut short and counted
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         wrap_up();
      end
   end
   // inputs always move 1 ns after the rising edge
   task automatic tick();
      @(posedge clk);
      #1;
   endtask : tick
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         $display("BAD %0t got %h exp %h", $time, got, exp);
         miscompares++;
      end
   endtask : chk
   // two-word instruction straight into host memory
   task automatic instr(input logic [31:0] a, input logic [3:0] op,
      input logic [11:0] len, input logic [31:0] dst);
      part.mem[a[9:2]] = {op, 16'h0000, len};
      part.mem[a[9:2] + 8'h01] = dst;
   endtask : instr
   task automatic go(input logic [31:0] base);
      prog_base = base;
      enable = 1'b1;
      tick();
   endtask : go
   // wait for the program to start and stop, then disable
   task automatic finish_run();
      for (int n = 0; n < 10 && busy !== 1'b1; n++)
         tick();
      for (int n = 0; n < 3000 && busy !== 1'b0; n++)
         tick();
      chk(busy, 1'b0);
      enable = 1'b0;
      tick();
   endtask : finish_run
   // strobe held 4 clocks each side so the synchroniser sees it
   task automatic par_unit(input logic [15:0] d);
      gpio = d;
      repeat (4) tick();
      par_stb = 1'b1;
      repeat (4) tick();
      par_stb = 1'b0;
      repeat (4) tick();
   endtask : par_unit
   // 16 bits, msb first; data line flips once the unit is over
   task automatic ser_unit(input logic [15:0] d);
      for (int i = 15; i >= 0; i--)
      begin
         ser_dat = d[i];
         repeat (4) tick();
         ser_clk = 1'b1;
         repeat (4) tick();
         ser_clk = 1'b0;
      end
      ser_dat = ~ser_dat;
   endtask : ser_unit
   task automatic t_bad_opcode();
      w = part.wr_cnt;
      instr(32'h0C0, 4'h3, 12'h001, 32'h200);
      go(32'h0C0);
      finish_run();
      chk(instr_err, 1'b1);
      chk(part.wr_cnt - w, 0);
   endtask : t_bad_opcode
   // 8-bit units, first byte in lane 0, first fetch retried
   task automatic t_pack8();
      src_par = 1'b1;
      wide = 1'b0;
      retry_once = 1'b1;
      w = part.wr_cnt;
      instr(32'h000, atd_pkg::OP_WRITE, 12'h002, 32'h200);
      instr(32'h008, atd_pkg::OP_STOP, 12'h000, 32'h0);
      go(32'h000);
      for (int k = 0; k < 8; k++)
         par_unit(16'hEE11 + 16'(k)); // high byte must be ignored
      finish_run();
      retry_once = 1'b0;
      chk(part.mem[8'h80], 32'h1413_1211);
      chk(part.mem[8'h81], 32'h1817_1615);
      chk(part.wr_cnt - w, 2);
      chk(part.par_bad, 0);
      chk(instr_err, 1'b0);
   endtask : t_pack8
   // 16-bit serial units reached through a jump
   task automatic t_ser16();
      src_par = 1'b0;
      wide = 1'b1;
      instr(32'h040, atd_pkg::OP_JUMP, 12'h000, 32'h080);
      instr(32'h080, atd_pkg::OP_WRITE, 12'h001, 32'h210);
      instr(32'h088, atd_pkg::OP_STOP, 12'h000, 32'h0);
      go(32'h040);
      ser_unit(16'hA5C3);
      ser_unit(16'h1234);
      finish_run();
      chk(part.mem[8'h84], 32'h1234_A5C3);
   endtask : t_ser16
   // host stalls; 36 dwords arrive, 35 fit, one is dropped
   task automatic t_overrun();
      src_par = 1'b1;
      wide = 1'b1;
      stall = 1'b1;
      w = part.wr_cnt;
      instr(32'h100, atd_pkg::OP_WRITE, 12'h023, 32'h300);
      instr(32'h108, atd_pkg::OP_STOP, 12'h000, 32'h0);
      go(32'h100);
      for (int k = 0; k < 72; k++)
         par_unit(16'hC000 + 16'(k));
      repeat (4) tick();
      chk(fill, atd_pkg::FIFO_FULL_CNT);
      chk(overrun, 1'b1);
      stall = 1'b0;
      finish_run();
      chk(fill, 6'h00);
      chk(part.wr_cnt - w, 35);
      chk(part.mem[8'hC0], 32'hC001_C000);
      chk(part.mem[8'hE2], 32'hC045_C044);
      chk(overrun, 1'b1);
      ovr_clr = 1'b1;
      tick();
      ovr_clr = 1'b0;
      repeat (2) tick();
      chk(overrun, 1'b0);
   endtask : t_overrun
   initial
   begin
      repeat (6) tick();
      rstn = 1'b1;
      tick();
      chk(bm.valid, 1'b0);
      chk(fill, 6'h00);
      t_bad_opcode();
      t_pack8();
      t_ser16();
      t_overrun();
      wrap_up();
   end
endmodule : audio_transport_dma_test
`default_nettype wire
